/* bcr_round_unit.v */
// Purpose: Block cipher round unit, two-stage pipeline
// Assumes: Requests come from same-clock pipeline logic
// Notes:   One request per cycle, result one edge after it is taken
`timescale 1ns/1ps
`include "bcr_round_unit_map.vh"

// What this block does
// - Reports 10, 12 or 14 rounds for 128, 192, 256-bit keys
// - Offers a normal and a final encryption round on state and key
// - Offers normal and final decryption rounds, equivalent inverse form
// - Offers a standalone inverse column mixing operation
// - Offers a round key derivation assist operation
// - State from vector register; key from register or memory, one selected
// - State is four 32-bit words, word 3 at bits 127 to 96
// - Word j holds column j, row 0 in its low byte
// - Byte k maps to row k mod 4, column k div 4
// - First test-vector byte sits in bits 7:0, last in the top byte
// - Column mixing uses matrix 02,03,01,01 rotated per row
// - Row shifting rotates rows 1,2,3 left by 1,2,3 bytes
// - Byte substitution looks up a 16x16 table by nibbles
// - Inverse column mixing uses matrix 0e,0b,0d,09 rotated per row
module bcr_round_unit (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         req_valid,
  input  wire [2:0]   req_op,
  input  wire [1:0]   req_key_len,
  input  wire [127:0] req_state,
  input  wire [127:0] req_key_reg,
  input  wire [127:0] req_key_mem,
  input  wire         req_key_from_mem,
  input  wire [7:0]   req_imm,
  output reg          res_valid_q,
  output reg  [127:0] res_data_q,
  output reg  [3:0]   res_rounds_q,
  output reg          res_bad_op_q
);

  localparam [2047:0] SBOX_TBL = `BCR_SBOX_TBL;

  // ----------------------------------------------------------------
  // Byte field arithmetic
  // ----------------------------------------------------------------
  function [7:0] xt;
    input [7:0] b;
    begin
      xt = {b[6:0], 1'b0} ^ (b[7] ? `BCR_FIELD_RED : `BCR_ZERO_BYTE);
    end
  endfunction

  function [7:0] gmul;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] p;
    reg   [7:0] t;
    integer     i;
    begin
      p = `BCR_ZERO_BYTE;
      t = a;
      for (i = 0; i < 8; i = i + 1) begin
        if (b[i]) begin
          p = p ^ t;
        end
        t = xt(t);
      end
      gmul = p;
    end
  endfunction

  // Multiplicative inverse as x^254, zero maps to zero
  function [7:0] ginv;
    input [7:0] x;
    reg   [7:0] sq;
    reg   [7:0] r;
    integer     i;
    begin
      sq = x;
      r  = `BCR_ONE;
      for (i = 1; i < 8; i = i + 1) begin
        sq = gmul(sq, sq);
        r  = gmul(r, sq);
      end
      ginv = r;
    end
  endfunction

  // ----------------------------------------------------------------
  // Substitution
  // ----------------------------------------------------------------
  function [7:0] sbox;
    input [7:0] b;
    reg   [7:0] idx;
    begin
      idx  = {b[7:4], b[3:0]};
      sbox = SBOX_TBL[`BCR_TBL_TOP - idx * 8 -: 8];
    end
  endfunction

  // Undo the affine step, then invert in the field
  function [7:0] inv_sbox;
    input [7:0] b;
    reg   [7:0] a;
    begin
      a = {b[6:0], b[7]} ^ {b[4:0], b[7:5]} ^ {b[1:0], b[7:2]}
          ^ `BCR_AFFINE_INV_C;
      inv_sbox = ginv(a);
    end
  endfunction

  function [127:0] sub_state;
    input [127:0] s;
    input         inv;
    integer       k;
    begin
      sub_state = `BCR_ZERO_STATE;
      for (k = 0; k < 16; k = k + 1) begin
        sub_state[k*8 +: 8] = inv ? inv_sbox(s[k*8 +: 8])
                                  : sbox(s[k*8 +: 8]);
      end
    end
  endfunction

  function [31:0] sub_word;
    input [31:0] w;
    begin
      sub_word = {sbox(w[31:24]), sbox(w[23:16]),
                  sbox(w[15:8]), sbox(w[7:0])};
    end
  endfunction

  // ----------------------------------------------------------------
  // Row shifting, byte k is row k%4, column k/4
  // ----------------------------------------------------------------
  function [127:0] shift_state;
    input [127:0] s;
    input         inv;
    integer       r;
    integer       c;
    integer       src;
    begin
      shift_state = `BCR_ZERO_STATE;
      for (c = 0; c < 4; c = c + 1) begin
        for (r = 0; r < 4; r = r + 1) begin
          // Forward: out(r,c)=in(r,c+r); inverse: in(r,c-r)
          src = inv ? ((c + 4 - r) % 4) : ((c + r) % 4);
          shift_state[(c*4 + r)*8 +: 8] = s[(src*4 + r)*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Column mixing, word j is column j, row 0 in its low byte
  // ----------------------------------------------------------------
  function [31:0] mix_col;
    input [31:0] w;
    reg   [7:0]  s0;
    reg   [7:0]  s1;
    reg   [7:0]  s2;
    reg   [7:0]  s3;
    begin
      s0 = w[7:0];
      s1 = w[15:8];
      s2 = w[23:16];
      s3 = w[31:24];
      mix_col[7:0]   = xt(s0) ^ xt(s1) ^ s1 ^ s2 ^ s3;
      mix_col[15:8]  = s0 ^ xt(s1) ^ xt(s2) ^ s2 ^ s3;
      mix_col[23:16] = s0 ^ s1 ^ xt(s2) ^ xt(s3) ^ s3;
      mix_col[31:24] = xt(s0) ^ s0 ^ s1 ^ s2 ^ xt(s3);
    end
  endfunction

  function [31:0] inv_mix_col;
    input [31:0] w;
    reg   [7:0]  s0;
    reg   [7:0]  s1;
    reg   [7:0]  s2;
    reg   [7:0]  s3;
    begin
      s0 = w[7:0];
      s1 = w[15:8];
      s2 = w[23:16];
      s3 = w[31:24];
      inv_mix_col[7:0]   = gmul(8'h0e, s0) ^ gmul(8'h0b, s1)
                         ^ gmul(8'h0d, s2) ^ gmul(8'h09, s3);
      inv_mix_col[15:8]  = gmul(8'h09, s0) ^ gmul(8'h0e, s1)
                         ^ gmul(8'h0b, s2) ^ gmul(8'h0d, s3);
      inv_mix_col[23:16] = gmul(8'h0d, s0) ^ gmul(8'h09, s1)
                         ^ gmul(8'h0e, s2) ^ gmul(8'h0b, s3);
      inv_mix_col[31:24] = gmul(8'h0b, s0) ^ gmul(8'h0d, s1)
                         ^ gmul(8'h09, s2) ^ gmul(8'h0e, s3);
    end
  endfunction

  function [127:0] mix_state;
    input [127:0] s;
    input         inv;
    integer       j;
    begin
      mix_state = `BCR_ZERO_STATE;
      for (j = 0; j < 4; j = j + 1) begin
        mix_state[j*32 +: 32] = inv ? inv_mix_col(s[j*32 +: 32])
                                    : mix_col(s[j*32 +: 32]);
      end
    end
  endfunction

  function [3:0] round_count;
    input [1:0] klen;
    begin
      if (klen == `BCR_KLEN_192) begin
        round_count = `BCR_ROUNDS_192;
      end else if (klen == `BCR_KLEN_256) begin
        round_count = `BCR_ROUNDS_256;
      end else begin
        round_count = `BCR_ROUNDS_128;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Stage 1: capture request
  // ----------------------------------------------------------------
  reg         vld_q;
  reg [2:0]   op_q;
  reg [1:0]   klen_q;
  reg [127:0] state_q;
  reg [127:0] key_q;
  reg [7:0]   imm_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      vld_q   <= 1'b0;
      op_q    <= `BCR_OP_ENC;
      klen_q  <= `BCR_KLEN_128;
      state_q <= `BCR_ZERO_STATE;
      key_q   <= `BCR_ZERO_STATE;
      imm_q   <= `BCR_ZERO_BYTE;
    end else begin
      vld_q <= req_valid;
      if (req_valid) begin
        op_q    <= req_op;
        klen_q  <= req_key_len;
        state_q <= req_state;
        key_q   <= req_key_from_mem ? req_key_mem
                                    : req_key_reg;
        imm_q   <= req_imm;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage 2: compute; bit 7:0 is the first test-vector byte
  // ----------------------------------------------------------------
  wire [127:0] enc_sr   = shift_state(state_q, 1'b0);
  wire [127:0] enc_sb   = sub_state(enc_sr, 1'b0);
  wire [127:0] enc_mc   = mix_state(enc_sb, 1'b0);
  wire [127:0] dec_sr   = shift_state(state_q, 1'b1);
  wire [127:0] dec_sb   = sub_state(dec_sr, 1'b1);
  wire [127:0] dec_mc   = mix_state(dec_sb, 1'b1);
  wire [127:0] imc_res  = mix_state(state_q, 1'b1);
  wire [31:0]  sw1      = sub_word(state_q[63:32]);
  wire [31:0]  sw3      = sub_word(state_q[127:96]);
  wire [31:0]  rcon     = {24'h0, imm_q};

  reg  [127:0] res_d;
  reg          bad_d;

  always @* begin
    res_d = `BCR_ZERO_STATE;
    bad_d = 1'b0;
    case (op_q)
      `BCR_OP_ENC:      res_d = enc_mc ^ key_q;
      `BCR_OP_ENC_LAST: res_d = enc_sb ^ key_q;
      `BCR_OP_DEC:      res_d = dec_mc ^ key_q;
      `BCR_OP_DEC_LAST: res_d = dec_sb ^ key_q;
      `BCR_OP_IMC:      res_d = imc_res;
      `BCR_OP_KEYGEN:   res_d = {{sw3[7:0], sw3[31:8]} ^ rcon, sw3,
                                 {sw1[7:0], sw1[31:8]} ^ rcon, sw1};
      default:          bad_d = 1'b1;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      res_valid_q  <= 1'b0;
      res_data_q   <= `BCR_ZERO_STATE;
      res_rounds_q <= `BCR_ROUNDS_128;
      res_bad_op_q <= 1'b0;
    end else begin
      res_valid_q <= vld_q;
      if (vld_q) begin
        res_data_q   <= res_d;
        res_rounds_q <= round_count(klen_q);
        res_bad_op_q <= bad_d;
      end
    end
  end

endmodule // bcr_round_unit

/* bcr_round_unit_map.vh */
// Purpose: Constants for the block cipher round unit
// Assumes: Included by the unit, its checker and its bench
// Notes:   Operation codes, field constants and the substitution table
`ifndef BCR_ROUND_UNIT_MAP_VH
`define BCR_ROUND_UNIT_MAP_VH

// ------------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------------
`define BCR_OP_W           3
`define BCR_OP_ENC         3'h0
`define BCR_OP_ENC_LAST    3'h1
`define BCR_OP_DEC         3'h2
`define BCR_OP_DEC_LAST    3'h3
`define BCR_OP_IMC         3'h4
`define BCR_OP_KEYGEN      3'h5

// ------------------------------------------------------------------
// Key length codes and round counts
// ------------------------------------------------------------------
`define BCR_KLEN_128       2'h0
`define BCR_KLEN_192       2'h1
`define BCR_KLEN_256       2'h2
`define BCR_ROUNDS_128     4'ha
`define BCR_ROUNDS_192     4'hc
`define BCR_ROUNDS_256     4'he

// ------------------------------------------------------------------
// Byte field constants
// ------------------------------------------------------------------
`define BCR_FIELD_RED      8'h1b
`define BCR_AFFINE_INV_C   8'h05
`define BCR_ONE            8'h01
`define BCR_ZERO_BYTE      8'h00
`define BCR_ZERO_STATE     128'h0
`define BCR_TBL_TOP        2047

// Forward table, entry 0 in the top byte, rows by high nibble
`define BCR_SBOX_TBL {\
 128'h637c777bf26b6fc53001672bfed7ab76,\
 128'hca82c97dfa5947f0add4a2af9ca472c0,\
 128'hb7fd9326363ff7cc34a5e5f171d83115,\
 128'h04c723c31896059a071280e2eb27b275,\
 128'h09832c1a1b6e5aa0523bd6b329e32f84,\
 128'h53d100ed20fcb15b6acbbe394a4c58cf,\
 128'hd0efaafb434d338545f9027f503c9fa8,\
 128'h51a3408f929d38f5bcb6da2110fff3d2,\
 128'hcd0c13ec5f974417c4a77e3d645d1973,\
 128'h60814fdc222a908846eeb814de5e0bdb,\
 128'he0323a0a4906245cc2d3ac629195e479,\
 128'he7c8376d8dd54ea96c56f4ea657aae08,\
 128'hba78252e1ca6b4c6e8dd741f4bbd8b8a,\
 128'h703eb5664803f60e613557b986c11d9e,\
 128'he1f8981169d98e949b1e87e9ce5528df,\
 128'h8ca1890dbfe6426841992d0fb054bb16}

`endif

/* bcr_round_unit_chk.sv */
// Purpose: Port assertions for the round unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the unit
`timescale 1ns/1ps
`include "bcr_round_unit_map.vh"
module bcr_round_unit_chk (
  input wire         clk_sys,
  input wire         rst_n,
  input wire         req_valid,
  input wire [2:0]   req_op,
  input wire [1:0]   req_key_len,
  input wire [127:0] req_state,
  input wire [127:0] req_key_reg,
  input wire [127:0] req_key_mem,
  input wire         req_key_from_mem,
  input wire [7:0]   req_imm,
  input wire         res_valid_q,
  input wire [127:0] res_data_q,
  input wire [3:0]   res_rounds_q,
  input wire         res_bad_op_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_valid_lat:
    assert property (req_valid |-> ##2 res_valid_q) else $error("late result");
  chk_no_spurious:
    assert property (res_valid_q |-> $past(req_valid && rst_n, 2))
    else $error("result without request");
  chk_rounds_128:
    assert property (req_valid && req_key_len[0] == req_key_len[1]
      |-> ##2 res_rounds_q == `BCR_ROUNDS_128) else $error("rounds 128");
  chk_rounds_192:
    assert property (req_valid && req_key_len == `BCR_KLEN_192
      |-> ##2 res_rounds_q == `BCR_ROUNDS_192) else $error("rounds 192");
  chk_rounds_256:
    assert property (req_valid && req_key_len == `BCR_KLEN_256
      |-> ##2 res_rounds_q == `BCR_ROUNDS_256) else $error("rounds 256");
  chk_bad_op:
    assert property (req_valid && req_op > `BCR_OP_KEYGEN
      |-> ##2 res_bad_op_q && res_data_q == 128'h0) else $error("bad op");
  chk_good_op:
    assert property (req_valid && req_op <= `BCR_OP_KEYGEN
      |-> ##2 !res_bad_op_q) else $error("good op flagged");
  chk_hold_data:
    assert property (!res_valid_q |-> $stable(res_data_q))
    else $error("data moved");
  chk_key_src:
    assert property (req_valid && req_op == `BCR_OP_ENC_LAST && req_state == 0
      |-> ##2 res_data_q == ({16{8'h63}} ^ $past(req_key_from_mem ?
      req_key_mem : req_key_reg, 2))) else $error("key source");
  chk_reset_vals:
    assert property (disable iff (1'b0) !rst_n |=> !res_valid_q &&
      !res_bad_op_q && res_rounds_q == `BCR_ROUNDS_128 && res_data_q == 0)
    else $error("reset values");
  cover property (req_valid && req_op == `BCR_OP_ENC ##2 res_valid_q);
  cover property (req_valid [*2]);
  cover property (res_valid_q && res_bad_op_q);
endmodule // bcr_round_unit_chk

bind bcr_round_unit bcr_round_unit_chk chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
  .req_op(req_op), .req_key_len(req_key_len), .req_state(req_state),
  .req_key_reg(req_key_reg), .req_key_mem(req_key_mem),
  .req_key_from_mem(req_key_from_mem), .req_imm(req_imm),
  .res_valid_q(res_valid_q), .res_data_q(res_data_q),
  .res_rounds_q(res_rounds_q), .res_bad_op_q(res_bad_op_q));

/* bcr_pipe_model.sv */
// Purpose: Instruction pipeline stand-in feeding the round unit
// Assumes: Tasks called from the bench, drives at falling edge
// Notes:   Unused key source and idle operands carry inverted data
`timescale 1ns/1ps
module bcr_pipe_model (
  input  wire         clk_sys,
  output reg          req_valid,
  output reg  [2:0]   req_op,
  output reg  [1:0]   req_key_len,
  output reg  [127:0] req_state,
  output reg  [127:0] req_key_reg,
  output reg  [127:0] req_key_mem,
  output reg          req_key_from_mem,
  output reg  [7:0]   req_imm
);
  initial begin
    {req_valid, req_op, req_key_len, req_key_from_mem, req_imm} = 0;
    {req_state, req_key_reg, req_key_mem} = 0;
  end
  task issue(input [2:0] op, input [1:0] kl, input [127:0] st, k,
             input mem, input [7:0] imm);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_op = op;
    req_key_len = kl;
    req_state = st;
    req_imm = imm;
    req_key_from_mem = mem;
    req_key_reg = mem ? ~k : k;
    req_key_mem = mem ? k : ~k;
  endtask
  task idle;
    @(negedge clk_sys);
    req_valid = 1'b0;
    req_state = ~req_state;
    req_key_reg = ~req_key_reg;
    req_key_mem = ~req_key_mem;
  endtask
endmodule // bcr_pipe_model

/* bcr_round_unit_test.sv */
// Purpose: Self-checking bench for the round unit
// Assumes: Expectations from a local reference of the round steps, or literal values in t_known
// Notes:   Results are matched in order by a monitor
`timescale 1ns/1ps
`include "bcr_round_unit_map.vh"
module bcr_round_unit_test;
  localparam [127:0] BASE = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam [131:0] RST_V = {`BCR_ROUNDS_128, 128'h0};
  reg          clk_sys;
  reg          rst_n;
  wire         req_valid, req_key_from_mem, res_valid_q, res_bad_op_q;
  wire [2:0]   req_op;
  wire [1:0]   req_key_len;
  wire [7:0]   req_imm;
  wire [3:0]   res_rounds_q;
  wire [127:0] req_state, req_key_reg, req_key_mem, res_data_q;
  wire [132:0] seen = {res_bad_op_q, res_rounds_q, res_data_q};
  integer      fails, checks, i;
  reg  [132:0] q[$];

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  bcr_pipe_model PM (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_op(req_op), .req_key_len(req_key_len), .req_state(req_state),
    .req_key_reg(req_key_reg), .req_key_mem(req_key_mem),
    .req_key_from_mem(req_key_from_mem), .req_imm(req_imm));
  bcr_round_unit DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .req_valid(req_valid), .req_op(req_op), .req_key_len(req_key_len),
    .req_state(req_state), .req_key_reg(req_key_reg),
    .req_key_mem(req_key_mem), .req_key_from_mem(req_key_from_mem),
    .req_imm(req_imm), .res_valid_q(res_valid_q), .res_data_q(res_data_q),
    .res_rounds_q(res_rounds_q), .res_bad_op_q(res_bad_op_q));

  // ------
  // Reference round steps
  // ------
  function [7:0] sb(input [7:0] b);
    reg [2047:0] t;
    begin
      t = `BCR_SBOX_TBL;
      sb = t[2047-8*b -: 8];
    end
  endfunction
  function [7:0] isb(input [7:0] b);
    integer n;
    begin
      isb = 0;
      for (n = 0; n < 256; n++) if (sb(n[7:0]) == b) isb = n[7:0];
    end
  endfunction
  function [7:0] fm(input [7:0] a, input [7:0] b);
    integer n;
    begin
      fm = 0;
      for (n = 0; n < 8; n++) begin
        if (b[n]) fm = fm ^ a;
        a = {a[6:0], 1'b0} ^ (a[7] ? `BCR_FIELD_RED : 8'h00);
      end
    end
  endfunction
  function [127:0] mx(input [127:0] s, input [31:0] cf);
    integer c, r, n;
    begin
      mx = 0;
      for (c = 0; c < 4; c++) for (r = 0; r < 4; r++) for (n = 0; n < 4; n++)
        mx[8*(4*c+r)+:8] ^= fm(cf[31-8*n-:8], s[8*(4*c+(r+n)%4)+:8]);
    end
  endfunction
  function [127:0] rf(input [2:0] op, input [127:0] s, k, input [7:0] m);
    reg [127:0] t;
    reg [31:0]  a, b;
    integer     c, r;
    begin
      for (c = 0; c < 4; c++) begin
        a[8*c+:8] = sb(s[96+8*c+:8]);
        b[8*c+:8] = sb(s[32+8*c+:8]);
        for (r = 0; r < 4; r++)
          if (op < 2) t[8*(4*c+r)+:8] = sb(s[8*(4*((c+r)%4)+r)+:8]);
          else t[8*(4*c+r)+:8] = isb(s[8*(4*((c+4-r)%4)+r)+:8]);
      end
      if (op == 0) t = mx(t, 32'h02030101);
      if (op == 2) t = mx(t, 32'h0e0b0d09);
      rf = t ^ k;
      if (op == 4) rf = mx(s, 32'h0e0b0d09);
      if (op == 5) rf = {{a[7:0], a[31:8]} ^ {24'h0, m}, a,
                         {b[7:0], b[31:8]} ^ {24'h0, m}, b};
      if (op > 5) rf = 0;
    end
  endfunction

  // ------
  // Bench tasks
  // ------
  task chk(input [132:0] s, e, input string m);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task close_out;
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rq(input [2:0] op, input [1:0] kl, input [127:0] st, k, input mem);
    q.push_back({op > 5, kl == 1 ? `BCR_ROUNDS_192 : kl == 2 ?
      `BCR_ROUNDS_256 : `BCR_ROUNDS_128, rf(op, st, k, st[15:8])});
    PM.issue(op, kl, st, k, mem, st[15:8]);
  endtask
  task lit(input [2:0] op, input [127:0] st, k, e, input mem);
    q.push_back({1'b0, `BCR_ROUNDS_128, e});
    PM.issue(op, 2'h0, st, k, mem, 8'h00);
  endtask
  task drain;
    PM.idle;
    repeat (3) @(negedge clk_sys);
    chk(133'(q.size()), 133'h0, "results missing");
  endtask
  task t_known;
    lit(1, 0, BASE, {16{8'h63}} ^ BASE, 1);
    lit(1, 0, ~BASE, {16{8'h63}} ^ ~BASE, 0);
    lit(1, 128'h1, 0, {{15{8'h63}}, 8'h7c}, 0);
    lit(4, 0, BASE, 0, 1);
    drain;
  endtask
  task t_ops;
    for (i = 0; i < 6; i++)
      rq(i[2:0], i[1:0], BASE * (i + 1), ~BASE << i, i[0]);
    drain;
  endtask
  task t_bad;
    rq(6, 2, BASE, BASE, 0);
    rq(7, 1, BASE, BASE, 1);
    drain;
  endtask
  task t_midreset;
    PM.issue(0, 0, BASE, BASE, 0, 8'h00);
    PM.idle;
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(seen, {1'b0, RST_V}, "reset mid-run");
    rst_n = 1'b1;
    drain;
  endtask

  always @(posedge clk_sys) begin
    #1;
    if (res_valid_q === 1'b1) begin
      if (q.size() == 0) chk(133'h1, 133'h0, "extra result");
      else chk(seen, q.pop_front(), "result");
    end
  end
  initial begin
    #4000;
    fails++;
    close_out;
  end
  initial begin
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    chk({res_valid_q, seen[131:0]}, {1'b0, RST_V}, "reset");
    rst_n = 1'b1;
    t_known;
    t_ops;
    t_bad;
    t_midreset;
    close_out;
  end
endmodule // bcr_round_unit_test
